// File: hdl/sdc_pkg.sv
package sdc_pkg;
	localparam int NUM_CH = 7;
	localparam int RES_W = 32;
	localparam int HALF_W = 16;
	localparam int REG_W = 16;
	localparam int BYTE_W = 8;
	localparam int IDX_W = 10;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h100;
	localparam logic [IDX_W-1:0] IDX_IV = 10'h110;
	localparam logic [IDX_W-1:0] IDX_AE = 10'h0b7;
	localparam logic [IDX_W-1:0] IDX_CCTL0 = 10'h102;
	localparam logic [IDX_W-1:0] IDX_MEM0 = 10'h112;
	localparam logic [IDX_W-1:0] IDX_INCTL0 = 10'h0b0;
	localparam logic [IDX_W-1:0] IDX_PRE0 = 10'h0b8;
	// channel control fields
	localparam int B_BUF_LO = 13;
	localparam int B_UNI = 12;
	localparam int B_XOSR = 11;
	localparam int B_SNGL = 10;
	localparam int B_OSR_LO = 8;
	localparam int B_TOG = 7;
	localparam int B_ACC = 6;
	localparam int B_OVF = 5;
	localparam int B_DF = 4;
	localparam int B_IE = 3;
	localparam int B_IFG = 2;
	localparam int B_SC = 1;
	localparam int B_GRP = 0;
	localparam logic [REG_W-1:0] CCTL_WMASK = 16'h7fff;
	localparam logic [REG_W-1:0] CCTL_RST = 16'h0000;
	// shared control: overflow irq enable only
	localparam int B_OVIE = 1;
	// input control fields
	localparam int B_DLY_LO = 6;
	localparam int B_GAIN_LO = 3;
	localparam int B_INSEL_LO = 0;
	localparam logic [1:0] DLY_MAX = 2'h3;
	// interrupt vector codes
	localparam logic [REG_W-1:0] IV_NONE = 16'h0000;
	localparam logic [REG_W-1:0] IV_OVF = 16'h0002;
	localparam logic [REG_W-1:0] IV_CH0 = 16'h0004;
	localparam logic [REG_W-1:0] IV_STEP = 16'h0002;
	localparam logic [RES_W-1:0] OFFSET_FLIP = 32'h8000_0000;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} seq_e;
endpackage

// File: hdl/chan_seq.sv
`timescale 1ns/1ps
module chan_seq (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// control
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic single_in,
	input wire logic [1:0] delay_in,
	// filter samples
	input wire logic sample_in,
	output logic event_out,
	output logic done_out
);
	import sdc_pkg::*;

	seq_e state_r;
	logic [1:0] skip_r;

	assign event_out = sample_in && ((state_r == ST_WAIT && skip_r == 2'h0) || state_r == ST_RUN);
	assign done_out = event_out && single_in;

	// samples before the first result are swallowed
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= ST_IDLE;
			skip_r <= 2'h0;
		end else if (stop_in) begin
			state_r <= ST_IDLE;
		end else if (start_in) begin
			state_r <= ST_WAIT;
			skip_r <= DLY_MAX - delay_in;
		end else begin
			case (state_r)
				ST_WAIT: begin
					if (sample_in && skip_r != 2'h0) begin
						skip_r <= skip_r - 2'h1;
					end else if (sample_in) begin
						state_r <= single_in ? ST_IDLE : ST_RUN;
					end
				end
				ST_RUN: begin
					if (done_out) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// File: hdl/sigma_delta_channel_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - buffer mode field: 00 off, 01 slow, 10 medium, 11 high.
// - polarity bit 0 bipolar, 1 unipolar.
// - extended bit plus two-bit field pick the oversampling ratio.
// - single bit 0 continuous, 1 one conversion per start.
// - toggle bit flips half select on every result read.
// - half select 0 returns upper 16 bits, 1 lower.
// - overflow flag reads 1 while overflow pending.
// - format bit 0 offset binary, 1 two's complement.
// - per-channel enable gates result interrupt.
// - result flag set on new result, cleared by read or write.
// - writing start bit 1 begins conversion.
// - group bit starts next higher channel too; none on last.
// - first interrupt on fourth, third, second or first sample.
// - gain codes 000..101 give x1..x32; 110, 111 reserved.
// - input select: pairs 000..100, supply/11, temp, short.
// - result read returns chosen half of filter output.
// - eight-bit preload per channel loaded into filter.
// - analog enable bit 1 enables external input.
// - vector 004h..010h for channel 0..6 flags, 6 lowest.
// - any overflow gives 002h at top priority.
// - overflow request needs shared enable and global enable.
module sigma_delta_channel_ctrl #(
	parameter int NCH = sdc_pkg::NUM_CH,
	parameter int AE_W = 8
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// filter side
	input wire logic [NCH-1:0] sample_in,
	input wire logic [NCH*sdc_pkg::RES_W-1:0] sample_data_in,
	input wire logic [NCH-1:0] overflow_in,
	input wire logic global_irq_enable_in,
	// analog configuration
	output logic [NCH*2-1:0] input_buffer_mode_out,
	output logic [NCH-1:0] unipolar_select_out,
	output logic [NCH*3-1:0] oversample_ratio_out,
	output logic [NCH-1:0] converting_out,
	output logic [NCH*3-1:0] preamp_gain_out,
	output logic [NCH*3-1:0] input_select_out,
	output logic [NCH*8-1:0] channel_filter_preload_out,
	output logic [NCH-1:0] preload_load_out,
	output logic [AE_W-1:0] analog_input_enable_out,
	// interrupt
	output logic irq_out
);
	import sdc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// decode

	function automatic logic [3:0] ch_decode(
		input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] base,
		input logic step2
	);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < NCH; k++) begin
			if (idx == base + (step2 ? IDX_W'(2 * k) : IDX_W'(k))) begin
				r = {1'b1, 3'(k)};
			end
		end
		return r;
	endfunction

	logic [IDX_W-1:0] idx;
	logic [3:0] d_cctl, d_mem, d_inctl, d_pre;
	logic hit_ctrl, hit_iv, hit_ae, mapped;
	logic setup, done_xfer, wr, rd;

	assign idx = paddr_in[11:2];
	assign d_cctl = ch_decode(idx, IDX_CCTL0, 1'b1);
	assign d_mem = ch_decode(idx, IDX_MEM0, 1'b1);
	assign d_inctl = ch_decode(idx, IDX_INCTL0, 1'b0);
	assign d_pre = ch_decode(idx, IDX_PRE0, 1'b0);
	assign hit_ctrl = idx == IDX_CTRL;
	assign hit_iv = idx == IDX_IV;
	assign hit_ae = idx == IDX_AE;
	assign mapped = hit_ctrl | hit_iv | hit_ae | d_cctl[3] | d_mem[3] | d_inctl[3] | d_pre[3];
	assign setup = psel_in & ~penable_in;
	assign done_xfer = psel_in & penable_in & pready_out;
	assign wr = done_xfer & pwrite_in & mapped;
	assign rd = done_xfer & ~pwrite_in;

	////////////////////////////////////////////////////////////////////
	// registers

	logic [REG_W-1:0] cctl_r [NCH];
	logic [BYTE_W-1:0] inctl_r [NCH];
	logic [BYTE_W-1:0] pre_r [NCH];
	logic [RES_W-1:0] result_r [NCH];
	logic [AE_W-1:0] ae_r;
	logic ovie_r;
	logic [REG_W-1:0] iv_r, iv_nxt;
	logic irq_r;
	logic [NCH-1:0] load_r;

	logic [NCH-1:0] ev, sdone, rd_mem, wr_cctl, sw_start, start_p, stop_p;
	logic [NCH-1:0] ifg, ie, ovf, acc, tog, df;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ifg[i] = cctl_r[i][B_IFG];
			ie[i] = cctl_r[i][B_IE];
			ovf[i] = cctl_r[i][B_OVF];
			acc[i] = cctl_r[i][B_ACC];
			tog[i] = cctl_r[i][B_TOG];
			df[i] = cctl_r[i][B_DF];
			rd_mem[i] = rd & d_mem[3] & (d_mem[2:0] == 3'(i));
			wr_cctl[i] = wr & d_cctl[3] & (d_cctl[2:0] == 3'(i));
			sw_start[i] = wr_cctl[i] & pwdata_in[B_SC];
			stop_p[i] = (wr_cctl[i] & ~pwdata_in[B_SC]) | sdone[i];
		end
		// a grouped channel starts its upper neighbour in the same cycle
		start_p[0] = sw_start[0];
		for (int i = 1; i < NCH; i++) begin
			start_p[i] = sw_start[i] | (cctl_r[i-1][B_GRP] & start_p[i-1]);
		end
	end

	// channel control: hardware sets win over software and read clears
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NCH; i++) begin
				cctl_r[i] <= CCTL_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_cctl[i]) begin
					cctl_r[i] <= pwdata_in[REG_W-1:0] & CCTL_WMASK;
					if (i == NCH - 1) begin
						cctl_r[i][B_GRP] <= 1'b0;
					end
				end else begin
					if (rd_mem[i] & tog[i]) begin
						cctl_r[i][B_ACC] <= ~acc[i];
					end
					if (rd_mem[i]) begin
						cctl_r[i][B_IFG] <= 1'b0;
					end
					if (start_p[i]) begin
						cctl_r[i][B_SC] <= 1'b1;
					end else if (sdone[i]) begin
						cctl_r[i][B_SC] <= 1'b0;
					end
				end
				if (ev[i]) begin
					cctl_r[i][B_IFG] <= 1'b1;
				end
				if (overflow_in[i]) begin
					cctl_r[i][B_OVF] <= 1'b1;
				end
			end
		end
	end

	// conversion results, latched when a sample passes the delay
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NCH; i++) begin
				result_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (ev[i]) begin
					result_r[i] <= sample_data_in[i*RES_W +: RES_W];
				end
			end
		end
	end

	// input control, preload, analog enable, shared control
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NCH; i++) begin
				inctl_r[i] <= '0;
				pre_r[i] <= '0;
			end
			ae_r <= '0;
			ovie_r <= 1'b0;
			load_r <= '0;
		end else begin
			load_r <= '0;
			if (wr & d_inctl[3]) begin
				inctl_r[d_inctl[2:0]] <= pwdata_in[BYTE_W-1:0];
			end
			if (wr & d_pre[3]) begin
				pre_r[d_pre[2:0]] <= pwdata_in[BYTE_W-1:0];
				load_r[d_pre[2:0]] <= 1'b1;
			end
			if (wr & hit_ae) begin
				ae_r <= pwdata_in[AE_W-1:0];
			end
			if (wr & hit_ctrl) begin
				ovie_r <= pwdata_in[B_OVIE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencers

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_seq
			chan_seq u_seq (
				.clock_in(clock_in),
				.rstn_in(rstn_in),
				.start_in(start_p[g]),
				.stop_in(stop_p[g] & ~start_p[g]),
				.single_in(cctl_r[g][B_SNGL]),
				.delay_in(inctl_r[g][B_DLY_LO +: 2]),
				.sample_in(sample_in[g]),
				.event_out(ev[g]),
				.done_out(sdone[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// interrupt vector

	always_comb begin
		iv_nxt = IV_NONE;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (ifg[i] & ie[i]) begin
				iv_nxt = IV_CH0 + REG_W'(i) * IV_STEP;
			end
		end
		// vector cannot name the overflowing channel
		if ((|ovf) & ovie_r & global_irq_enable_in) begin
			iv_nxt = IV_OVF;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			iv_r <= IV_NONE;
			irq_r <= 1'b0;
		end else begin
			iv_r <= iv_nxt;
			irq_r <= iv_nxt != IV_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb read path; one wait-free access phase

	logic [31:0] rdata;
	logic [RES_W-1:0] res_fmt;

	always_comb begin
		rdata = '0;
		res_fmt = result_r[d_mem[2:0]];
		if (!df[d_mem[2:0]]) begin
			res_fmt = res_fmt ^ OFFSET_FLIP;
		end
		if (d_cctl[3]) begin
			rdata[REG_W-1:0] = cctl_r[d_cctl[2:0]];
		end else if (d_mem[3]) begin
			rdata[HALF_W-1:0] = acc[d_mem[2:0]] ? res_fmt[HALF_W-1:0] : res_fmt[RES_W-1:HALF_W];
		end else if (d_inctl[3]) begin
			rdata[BYTE_W-1:0] = inctl_r[d_inctl[2:0]];
		end else if (d_pre[3]) begin
			rdata[BYTE_W-1:0] = pre_r[d_pre[2:0]];
		end else if (hit_ae) begin
			rdata[AE_W-1:0] = ae_r;
		end else if (hit_iv) begin
			rdata[REG_W-1:0] = iv_r;
		end else if (hit_ctrl) begin
			rdata[B_OVIE] = ovie_r;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= '0;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= setup;
			pslverr_out <= setup & ~mapped;
			if (setup) begin
				prdata_out <= pwrite_in ? '0 : rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			input_buffer_mode_out[i*2 +: 2] = cctl_r[i][B_BUF_LO +: 2];
			unipolar_select_out[i] = cctl_r[i][B_UNI];
			oversample_ratio_out[i*3 +: 3] = {cctl_r[i][B_XOSR], cctl_r[i][B_OSR_LO +: 2]};
			converting_out[i] = cctl_r[i][B_SC];
			preamp_gain_out[i*3 +: 3] = inctl_r[i][B_GAIN_LO +: 3];
			input_select_out[i*3 +: 3] = inctl_r[i][B_INSEL_LO +: 3];
			channel_filter_preload_out[i*BYTE_W +: BYTE_W] = pre_r[i];
		end
	end

	assign preload_load_out = load_r;
	assign analog_input_enable_out = ae_r;
	assign irq_out = irq_r;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	chk_ovf_prio: assert property (
		((|ovf) & ovie_r & global_irq_enable_in) |=> iv_r == IV_OVF
	) else $error("overflow vector not taken");

	chk_ovf_gate: assert property (
		!global_irq_enable_in |=> iv_r != IV_OVF
	) else $error("overflow vector without global enable");

	chk_irq_level: assert property (
		irq_out == (iv_r != IV_NONE)
	) else $error("irq disagrees with vector");

	chk_iv_shape: assert property (
		iv_r[REG_W-1:5] == '0 && !iv_r[0]
	) else $error("vector outside bits 4..1");

	chk_ifg_set: assert property (
		ev[0] |=> ifg[0]
	) else $error("result flag not set");

	chk_ifg_read_clr: assert property (
		rd_mem[0] & ~ev[0] & ~wr_cctl[0] |=> !ifg[0]
	) else $error("result flag not cleared by read");

	chk_half_toggle: assert property (
		rd_mem[0] & tog[0] & ~wr_cctl[0] |=> acc[0] != $past(acc[0])
	) else $error("half select did not toggle");

	chk_half_hold: assert property (
		rd_mem[0] & ~tog[0] & ~wr_cctl[0] |=> $stable(acc[0])
	) else $error("half select changed without toggle");

	chk_start_bit: assert property (
		sw_start[0] |=> cctl_r[0][B_SC]
	) else $error("start bit not set");

	chk_ch0_vector: assert property (
		ifg[0] & ie[0] & ~(|ovf) ##1 ifg[0] & ie[0] & ~(|ovf) |-> iv_r == IV_CH0
	) else $error("channel 0 vector wrong");
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import sdc_pkg::*;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic [6:0] sample_in = 7'h00;
	logic [223:0] sample_data_in = '0;
	logic [6:0] overflow_in = 7'h00;
	logic global_irq_enable_in = 1'b0;
	logic [13:0] input_buffer_mode_out;
	logic [6:0] unipolar_select_out;
	logic [20:0] oversample_ratio_out;
	logic [6:0] converting_out;
	logic [20:0] preamp_gain_out;
	logic [20:0] input_select_out;
	logic [55:0] channel_filter_preload_out;
	logic [6:0] preload_load_out;
	logic [7:0] analog_input_enable_out;
	logic irq_out;
	int fails = 0;
	int comparisons = 0;
	logic [31:0] q;
	logic e;

	sigma_delta_channel_ctrl sigma_delta_channel_ctrl_inst (.clock_in(clock_in), .rstn_in(rstn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .sample_in(sample_in), .sample_data_in(sample_data_in),
		.overflow_in(overflow_in), .global_irq_enable_in(global_irq_enable_in),
		.input_buffer_mode_out(input_buffer_mode_out), .unipolar_select_out(unipolar_select_out),
		.oversample_ratio_out(oversample_ratio_out), .converting_out(converting_out),
		.preamp_gain_out(preamp_gain_out), .input_select_out(input_select_out),
		.channel_filter_preload_out(channel_filter_preload_out),
		.preload_load_out(preload_load_out), .analog_input_enable_out(analog_input_enable_out),
		.irq_out(irq_out));

	always #5 clock_in = ~clock_in;

	////////////////////////////////////////////////////////////////
	function automatic logic [9:0] cc(input int i);
		return IDX_CCTL0 + 10'(2 * i);
	endfunction
	function automatic logic [9:0] mm(input int i);
		return IDX_MEM0 + 10'(2 * i);
	endfunction
	function automatic logic [9:0] ic(input int i);
		return IDX_INCTL0 + 10'(i);
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// access phase held until pready is seen high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		begin
			@(posedge clock_in);
			psel_in <= 1'b1;
			penable_in <= 1'b0;
			pwrite_in <= w;
			paddr_in <= {idx, 2'b00};
			pwdata_in <= d;
			@(posedge clock_in);
			penable_in <= 1'b1;
			for (n = 0; n < 20; n++) begin
				@(posedge clock_in);
				if (pready_out === 1'b1) break;
			end
			if (n == 20) begin
				fails++;
				end_sim();
			end
			q = prdata_out;
			e = pslverr_out;
			psel_in <= 1'b0;
			penable_in <= 1'b0;
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(q, exp);
	endtask

	task automatic ev(input logic [6:0] s, input logic [6:0] o, input logic [31:0] d);
		@(posedge clock_in);
		sample_in <= s;
		overflow_in <= o;
		sample_data_in <= {7{d}};
		@(posedge clock_in);
		sample_in <= 7'h00;
		overflow_in <= 7'h00;
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clock_in);
		fails++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clock_in);
		rstn_in <= 1'b1;
		rd(cc(0), 32'h0000);
		rd(ic(0), 32'h0000);
		rd(IDX_AE, 32'h0000);
		rd(IDX_IV, 32'h0000);
		apb(1'b0, 10'h1ff, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		wr(cc(1), 32'h8000);
		rd(cc(1), 32'h0000);
		done("reset");
		for (int c = 0; c < 4; c++) begin
			wr(cc(1), (32'(c) << 13) | (32'(c & 1) << 12) | (32'(c >> 1) << 11) | (32'(c) << 8));
			@(negedge clock_in);
			chk(input_buffer_mode_out[3:2], 32'(c));
			chk(unipolar_select_out[1], 32'(c & 1));
			chk(oversample_ratio_out[5:3], 32'((c >> 1) * 4 + c));
		end
		for (int c = 0; c < 8; c++) begin
			wr(ic(2), 32'(c * 8 + 7 - c));
			@(negedge clock_in);
			chk(preamp_gain_out[8:6], 32'(c));
			chk(input_select_out[8:6], 32'(7 - c));
			rd(ic(2), 32'(c * 8 + 7 - c));
		end
		wr(IDX_PRE0 + 10'h3, 32'h5a);
		@(negedge clock_in);
		chk(preload_load_out, 32'h08);
		rd(IDX_PRE0 + 10'h3, 32'h5a);
		chk(channel_filter_preload_out[31:24], 32'h5a);
		wr(IDX_AE, 32'ha5);
		rd(IDX_AE, 32'ha5);
		chk(analog_input_enable_out, 32'ha5);
		done("fields");
		// first accepted sample comes later for lower delay codes
		for (int d = 0; d < 4; d++) begin
			wr(ic(0), 32'(d) << 6);
			wr(cc(0), 32'h001a);
			for (int k = 1; k < 4 - d; k++) begin
				ev(7'h01, 7'h00, 32'h1234_5678);
				rd(cc(0), 32'h001a);
			end
			ev(7'h01, 7'h00, 32'h1234_5678);
			rd(cc(0), 32'h001e);
			rd(IDX_IV, 32'h0004);
			@(negedge clock_in);
			chk(irq_out, 32'h1);
			rd(mm(0), 32'h1234);
			rd(IDX_IV, 32'h0000);
		end
		wr(cc(0), 32'h0082);
		ev(7'h01, 7'h00, 32'h1234_5678);
		rd(mm(0), 32'h9234);
		rd(mm(0), 32'h5678);
		rd(mm(0), 32'h9234);
		rd(cc(0), 32'h00c2);
		wr(cc(0), 32'h0000);
		done("conversion");
		wr(ic(5), 32'hc0);
		wr(ic(6), 32'hc0);
		wr(cc(5), 32'h000a);
		wr(cc(6), 32'h000a);
		// offset binary: sign bit of the two's complement sample is inverted
		ev(7'h60, 7'h00, 32'hfedc_ba98);
		rd(IDX_IV, 32'h000e);
		rd(mm(5), 32'h7edc);
		rd(IDX_IV, 32'h0010);
		rd(mm(6), 32'h7edc);
		wr(cc(6), 32'h0002);
		ev(7'h40, 7'h00, 32'h0);
		rd(IDX_IV, 32'h0000);
		rd(cc(6), 32'h0006);
		wr(cc(6), 32'h0002);
		rd(cc(6), 32'h0002);
		wr(cc(6), 32'h0001);
		rd(cc(6), 32'h0000);
		wr(cc(5), 32'h0000);
		done("priority");
		ev(7'h00, 7'h10, 32'h0);
		rd(cc(4), 32'h0020);
		rd(IDX_IV, 32'h0000);
		wr(IDX_CTRL, 32'hffff);
		rd(IDX_CTRL, 32'h0002);
		rd(IDX_IV, 32'h0000);
		@(posedge clock_in);
		global_irq_enable_in <= 1'b1;
		rd(IDX_IV, 32'h0002);
		wr(IDX_IV, 32'h0000);
		rd(IDX_IV, 32'h0002);
		wr(cc(4), 32'h0000);
		rd(IDX_IV, 32'h0000);
		@(negedge clock_in);
		chk(irq_out, 32'h0);
		done("overflow");
		wr(ic(2), 32'hc0);
		// group bit must already stand when the start is written
		wr(cc(2), 32'h0401);
		wr(cc(2), 32'h0403);
		@(negedge clock_in);
		chk(converting_out[3:2], 32'h3);
		ev(7'h04, 7'h00, 32'h0);
		@(negedge clock_in);
		chk(converting_out[2], 32'h0);
		rd(cc(2), 32'h0405);
		wr(cc(2), 32'h0000);
		wr(cc(3), 32'h0000);
		done("single_group");
		end_sim();
	end
endmodule
